// [logic/fgw_defs.svh]
// register offsets, sizes and reset values of the fast gpio port block
`ifndef FGW_DEFS_SVH
`define FGW_DEFS_SVH

`define FGW_NP 5
`define FGW_NI 2
`define FGW_AW 12
`define FGW_INT_PORT_A 0
`define FGW_INT_PORT_B 2

`define FGW_PORT_STRIDE 12'h020
`define FGW_OFF_DIR 12'h000
`define FGW_OFF_MASK 12'h004
`define FGW_OFF_PIN 12'h008
`define FGW_OFF_SET 12'h00C
`define FGW_OFF_CLR 12'h010

`define FGW_LEG_BASE 12'h200
`define FGW_LEG_STRIDE 12'h010
`define FGW_LEG_PIN 12'h000
`define FGW_LEG_SET 12'h004
`define FGW_LEG_DIR 12'h008
`define FGW_LEG_CLR 12'h00C

`define FGW_INT_BASE 12'h300
`define FGW_INT_STRIDE 12'h020
`define FGW_INT_REN 12'h000
`define FGW_INT_FEN 12'h004
`define FGW_INT_RST 12'h008
`define FGW_INT_FST 12'h00C
`define FGW_INT_CLR 12'h010

`define FGW_RST_WORD 32'h0000_0000

`endif

// [logic/fgw_pkg.sv]
// types shared by the fast gpio port block
`include "fgw_defs.svh"
package fgw_pkg;
  typedef logic [`FGW_AW-1:0] fgw_addr_t;
  typedef logic [`FGW_NP-1:0][31:0] fgw_port_t;
  typedef logic [`FGW_NI-1:0][31:0] fgw_ipin_t;

  typedef struct packed {
    fgw_addr_t addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic wr;
    logic rd;
  } fgw_req_t;

  typedef struct packed {
    fgw_port_t out;
    fgw_port_t dir;
    fgw_port_t mask;
    fgw_port_t oe;
    fgw_port_t pin_s1;
    fgw_port_t pin_s2;
    fgw_port_t pin_s3;
    fgw_ipin_t ren;
    fgw_ipin_t fen;
    fgw_ipin_t rst;
    fgw_ipin_t fst;
    logic [31:0] rdata;
    logic irq;
    logic wake;
  } fgw_state_t;
endpackage

// [logic/fgw_port.sv]
// fast gpio ports with masked access, legacy views and edge wake-up
//
// Summary of operation
// RQ1 - pins handed to a peripheral function are never driven by the port.
// RQ2 - every bit has its own direction bit, writable at any time.
// RQ3 - separate set and clear registers change outputs without read-modify.
// RQ4 - output latch and synchronised pin level are both readable.
// RQ5 - mask bits are excluded from pin writes, reads, set and clear.
// RQ6 - byte, half-word and word writes touch only the enabled lanes.
// RQ7 - one pin-register write loads a whole port's outputs.
// RQ8 - each pin of two ports flags rising, falling or both edges.
// RQ9 - pins in analog use never raise edge flags.
// RQ10 - edge capture keeps working when clocks stop in power-down; here capture needs i_sys_clk kept running.
// RQ11 - any enabled edge flag drives the wake-up request.
// RQ12 - reset makes every bit an input with drivers off.
// RQ13 - legacy register views of ports 0 and 1 are also provided.
// RQ14 - edge requests merge onto the shared external interrupt line.
// RQ15 - rise and fall flags stay set until a one is written to clear.
// RQ16 - zero bits in set and clear writes leave the latch alone.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`include "fgw_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fgw_port (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire fgw_pkg::fgw_req_t i_bus,
  input wire fgw_pkg::fgw_port_t i_pin_in,
  input wire fgw_pkg::fgw_port_t i_func_sel,
  input wire fgw_pkg::fgw_ipin_t i_analog_sel,
  input wire logic i_ext_irq,
  output logic [31:0] o_rdata,
  output fgw_pkg::fgw_port_t o_pin_out,
  output fgw_pkg::fgw_port_t o_pin_oe,
  output logic o_shared_external_irq_line,
  output logic o_wake
);
  import fgw_pkg::*;

  fgw_state_t q;
  fgw_state_t d;
  logic clr_rise_a0;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic fgw_addr_t port_adr(input int p, input fgw_addr_t off);
    return fgw_addr_t'(p * `FGW_PORT_STRIDE) + off;
  endfunction

  function automatic fgw_addr_t leg_adr(input int l, input fgw_addr_t off);
    return `FGW_LEG_BASE + fgw_addr_t'(l * `FGW_LEG_STRIDE) + off;
  endfunction

  function automatic fgw_addr_t int_adr(input int k, input fgw_addr_t off);
    return `FGW_INT_BASE + fgw_addr_t'(k * `FGW_INT_STRIDE) + off;
  endfunction

  function automatic int int_port(input int k);
    return (k == 0) ? `FGW_INT_PORT_A : `FGW_INT_PORT_B;
  endfunction

  assign clr_rise_a0 = i_bus.wr &&
      i_bus.addr == int_adr(0, `FGW_INT_CLR) && i_bus.be[0] &&
      i_bus.wdata[0];

  always_comb begin
    logic [31:0] wm;
    logic [31:0] clrm;
    logic [31:0] rise;
    logic [31:0] fall;
    logic any_irq;
    wm = '0;
    clrm = '0;
    rise = '0;
    fall = '0;
    any_irq = 1'b0;
    d = q;
    d.rdata = `FGW_RST_WORD;
    // first stage feeds only the second stage
    d.pin_s1 = i_pin_in;
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;

    for (int p = 0; p < `FGW_NP; p++) begin
      wm = i_bus.wdata & ~q.mask[p];
      // drivers only where the port owns the pin and the bit is output
      d.oe[p] = q.dir[p] & ~i_func_sel[p]; // [RQ1] [RQ12]
      if (i_bus.wr) begin
        if (i_bus.addr == port_adr(p, `FGW_OFF_DIR)) begin
          d.dir[p] = lane_merge(q.dir[p], i_bus.wdata, i_bus.be); // [RQ2]
        end
        if (i_bus.addr == port_adr(p, `FGW_OFF_MASK)) begin
          d.mask[p] = lane_merge(q.mask[p], i_bus.wdata, i_bus.be); // [RQ6]
        end
        if (i_bus.addr == port_adr(p, `FGW_OFF_PIN)) begin
          d.out[p] = lane_merge(q.out[p],
              (q.out[p] & q.mask[p]) | wm, i_bus.be); // [RQ5] [RQ7]
        end
        if (i_bus.addr == port_adr(p, `FGW_OFF_SET)) begin
          d.out[p] = lane_merge(q.out[p], q.out[p] | wm,
                                i_bus.be); // [RQ3] [RQ16]
        end
        if (i_bus.addr == port_adr(p, `FGW_OFF_CLR)) begin
          d.out[p] = lane_merge(q.out[p], q.out[p] & ~wm,
                                i_bus.be); // [RQ3] [RQ16]
        end
      end
      if (i_bus.rd) begin
        if (i_bus.addr == port_adr(p, `FGW_OFF_DIR)) begin
          d.rdata = q.dir[p];
        end
        if (i_bus.addr == port_adr(p, `FGW_OFF_MASK)) begin
          d.rdata = q.mask[p];
        end
        if (i_bus.addr == port_adr(p, `FGW_OFF_PIN)) begin
          d.rdata = q.pin_s2[p] & ~q.mask[p]; // [RQ4] [RQ5]
        end
        if (i_bus.addr == port_adr(p, `FGW_OFF_SET)) begin
          d.rdata = q.out[p]; // [RQ4]
        end
      end
    end

    // legacy views ignore the mask, as older software expects
    for (int l = 0; l < 2; l++) begin
      if (i_bus.wr) begin
        if (i_bus.addr == leg_adr(l, `FGW_LEG_PIN)) begin
          d.out[l] = lane_merge(q.out[l], i_bus.wdata, i_bus.be); // [RQ13]
        end
        if (i_bus.addr == leg_adr(l, `FGW_LEG_SET)) begin
          d.out[l] = lane_merge(q.out[l], q.out[l] | i_bus.wdata,
                                i_bus.be); // [RQ13]
        end
        if (i_bus.addr == leg_adr(l, `FGW_LEG_DIR)) begin
          d.dir[l] = lane_merge(q.dir[l], i_bus.wdata, i_bus.be); // [RQ13]
        end
        if (i_bus.addr == leg_adr(l, `FGW_LEG_CLR)) begin
          d.out[l] = lane_merge(q.out[l], q.out[l] & ~i_bus.wdata,
                                i_bus.be); // [RQ13]
        end
      end
      if (i_bus.rd) begin
        if (i_bus.addr == leg_adr(l, `FGW_LEG_PIN)) begin
          d.rdata = q.pin_s2[l];
        end
        if (i_bus.addr == leg_adr(l, `FGW_LEG_SET)) begin
          d.rdata = q.out[l];
        end
        if (i_bus.addr == leg_adr(l, `FGW_LEG_DIR)) begin
          d.rdata = q.dir[l];
        end
      end
    end

    for (int k = 0; k < `FGW_NI; k++) begin
      // edges come from the synchronised level, analog pins excluded
      rise = q.pin_s2[int_port(k)] & ~q.pin_s3[int_port(k)] &
             ~i_analog_sel[k]; // [RQ8] [RQ9]
      fall = ~q.pin_s2[int_port(k)] & q.pin_s3[int_port(k)] &
             ~i_analog_sel[k]; // [RQ8] [RQ9]
      clrm = '0;
      if (i_bus.wr) begin
        if (i_bus.addr == int_adr(k, `FGW_INT_REN)) begin
          d.ren[k] = lane_merge(q.ren[k], i_bus.wdata, i_bus.be); // [RQ8]
        end
        if (i_bus.addr == int_adr(k, `FGW_INT_FEN)) begin
          d.fen[k] = lane_merge(q.fen[k], i_bus.wdata, i_bus.be); // [RQ8]
        end
        if (i_bus.addr == int_adr(k, `FGW_INT_CLR)) begin
          clrm = lane_merge('0, i_bus.wdata, i_bus.be);
        end
      end
      // a new edge in the clearing cycle survives the clear
      d.rst[k] = (q.rst[k] & ~clrm) | rise; // [RQ15]
      d.fst[k] = (q.fst[k] & ~clrm) | fall; // [RQ15]
      any_irq = any_irq | (|((q.rst[k] & q.ren[k]) |
                             (q.fst[k] & q.fen[k])));
      if (i_bus.rd) begin
        if (i_bus.addr == int_adr(k, `FGW_INT_REN)) begin
          d.rdata = q.ren[k];
        end
        if (i_bus.addr == int_adr(k, `FGW_INT_FEN)) begin
          d.rdata = q.fen[k];
        end
        if (i_bus.addr == int_adr(k, `FGW_INT_RST)) begin
          d.rdata = q.rst[k];
        end
        if (i_bus.addr == int_adr(k, `FGW_INT_FST)) begin
          d.rdata = q.fst[k];
        end
      end
    end

    // limitation: capture needs this clock, so power-down must keep it
    // running to this block; the wake level then holds until cleared
    d.wake = any_irq; // [RQ10] [RQ11]
    d.irq = any_irq | i_ext_irq; // [RQ14]
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      q <= '0; // [RQ12]
    end else begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_pin_out = q.out;
  assign o_pin_oe = q.oe;
  assign o_shared_external_irq_line = q.irq;
  assign o_wake = q.wake;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_set_word0;
    i_bus.wr && i_bus.addr == port_adr(0, `FGW_OFF_SET) &&
    i_bus.be == 4'hF;
  endsequence

  sequence s_clr_word0;
    i_bus.wr && i_bus.addr == port_adr(0, `FGW_OFF_CLR) &&
    i_bus.be == 4'hF;
  endsequence

  sequence s_rise_a0;
    q.pin_s2[`FGW_INT_PORT_A][0] && !q.pin_s3[`FGW_INT_PORT_A][0] &&
    !i_analog_sel[0][0];
  endsequence

  sequence s_fall_a0;
    !q.pin_s2[`FGW_INT_PORT_A][0] && q.pin_s3[`FGW_INT_PORT_A][0] &&
    !i_analog_sel[0][0];
  endsequence

  chk_reset_inputs: assert property (@(posedge i_sys_clk) // [RQ12]
    disable iff (1'b0) i_srst |=> o_pin_oe == '0 && q.dir == '0)
    else $error("drivers not off after reset");

  chk_oe_follow: assert property ( // [RQ1]
    ##1 o_pin_oe[1] == ($past(q.dir[1]) & ~$past(i_func_sel[1])))
    else $error("output enable ignores direction or function");

  chk_set_bits: assert property ( // [RQ3]
    s_set_word0 |=> ((o_pin_out[0] & $past(i_bus.wdata & ~q.mask[0]))
                     == $past(i_bus.wdata & ~q.mask[0])))
    else $error("set write did not raise bits");

  chk_clr_keep: assert property ( // [RQ16]
    s_clr_word0 |=> ((o_pin_out[0] & ~$past(i_bus.wdata & ~q.mask[0]))
                     == ($past(q.out[0]) & ~$past(i_bus.wdata & ~q.mask[0]))))
    else $error("clear write disturbed other bits");

  chk_pin_read: assert property ( // [RQ4] [RQ5]
    (i_bus.rd && i_bus.addr == port_adr(0, `FGW_OFF_PIN)) |=>
      o_rdata == ($past(q.pin_s2[0]) & ~$past(q.mask[0])))
    else $error("masked pin read wrong");

  chk_byte_lane: assert property ( // [RQ6]
    (i_bus.wr && i_bus.addr == port_adr(0, `FGW_OFF_DIR) &&
     i_bus.be == 4'h1) |=> $stable(q.dir[0][31:8]))
    else $error("byte write touched other lanes");

  chk_rise_flag: assert property ( // [RQ8] [RQ9]
    s_rise_a0 |=> q.rst[0][0])
    else $error("rising edge not flagged");

  chk_flag_sticky: assert property ( // [RQ15]
    (q.rst[0][0] && !clr_rise_a0) |=> q.rst[0][0])
    else $error("edge flag dropped without clear");

  chk_irq_merge: assert property ( // [RQ14]
    i_ext_irq |=> o_shared_external_irq_line)
    else $error("external request not merged");

  chk_wake_edge: assert property ( // [RQ11]
    (q.ren[0][0] && !clr_rise_a0) ##0 s_rise_a0 |=> ##1 o_wake)
    else $error("enabled edge did not wake");

  chk_legacy_set: assert property ( // [RQ13]
    (i_bus.wr && i_bus.addr == leg_adr(1, `FGW_LEG_SET) &&
     i_bus.be == 4'hF) |=> ((o_pin_out[1] | ~$past(i_bus.wdata)) == '1))
    else $error("legacy set write lost");

  chk_fall_flag: assert property ( // [RQ8] [RQ9]
    s_fall_a0 |=> q.fst[0][0])
    else $error("falling edge not flagged");

  chk_analog_quiet: assert property ( // [RQ9]
    (i_analog_sel[0][7] && !q.rst[0][7]) |=> !q.rst[0][7])
    else $error("analog pin raised a rise flag");

  chk_flag_clear: assert property ( // [RQ15]
    (clr_rise_a0 &&
     !(q.pin_s2[`FGW_INT_PORT_A][0] && !q.pin_s3[`FGW_INT_PORT_A][0]))
      |=> !q.rst[0][0])
    else $error("edge flag survived its clear");

  chk_dir_write: assert property ( // [RQ2]
    (i_bus.wr && i_bus.addr == port_adr(1, `FGW_OFF_DIR) &&
     i_bus.be == 4'hF) |=> q.dir[1] == $past(i_bus.wdata))
    else $error("direction write lost");

  chk_pin_write: assert property ( // [RQ5] [RQ7]
    (i_bus.wr && i_bus.addr == port_adr(1, `FGW_OFF_PIN) &&
     i_bus.be == 4'hF) |=>
      o_pin_out[1] == (($past(q.out[1]) & $past(q.mask[1])) |
                       ($past(i_bus.wdata) & ~$past(q.mask[1]))))
    else $error("masked port write wrong");

  chk_oe_func: assert property ( // [RQ1]
    i_func_sel[1][0] |=> !o_pin_oe[1][0])
    else $error("pin driven while a peripheral owns it");

  chk_read_idle: assert property ( // [RQ4]
    !i_bus.rd |=> o_rdata == '0)
    else $error("read data outside the read cycle");

  chk_wake_irq: assert property ( // [RQ11] [RQ14]
    o_wake |-> o_shared_external_irq_line)
    else $error("wake request missing from interrupt line");

  chk_ren_write: assert property ( // [RQ8]
    (i_bus.wr && i_bus.addr == int_adr(0, `FGW_INT_REN) &&
     i_bus.be == 4'hF) |=> q.ren[0] == $past(i_bus.wdata))
    else $error("rise enable write lost");
endmodule

`default_nettype wire

// [test/fgw_pad_model.sv]
// pad ring model: driven bits follow the latch, others the outside level
`timescale 1ns/1ps
`default_nettype none

module fgw_pad_model (
  input wire fgw_pkg::fgw_port_t i_out,
  input wire fgw_pkg::fgw_port_t i_oe,
  input wire fgw_pkg::fgw_port_t i_ext,
  output fgw_pkg::fgw_port_t o_pin
);
  import fgw_pkg::*;
  // an enabled driver wins over whatever the board puts on the pin
  assign o_pin = (i_out & i_oe) | (i_ext & ~i_oe);
endmodule

`default_nettype wire

// [test/fast_gpio_edge_wake_port_bench.sv]
// self-checking bench for the fast gpio port block
`include "fgw_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module fast_gpio_edge_wake_port_bench;
  import fgw_pkg::*;
  localparam fgw_addr_t p1_base = `FGW_PORT_STRIDE;
  localparam fgw_addr_t leg1 = `FGW_LEG_BASE + `FGW_LEG_STRIDE;
  localparam fgw_addr_t ie0 = `FGW_INT_BASE;
  localparam fgw_addr_t ie1 = `FGW_INT_BASE + `FGW_INT_STRIDE;
  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  fgw_req_t bus = '0;
  fgw_port_t ext = '0;
  fgw_port_t func = '0;
  fgw_port_t pins, out, oe;
  fgw_ipin_t ana = '0;
  logic ext_irq = 1'b0;
  logic [31:0] rdata;
  logic irq, wake;
  int fails = 0;
  int n_checks = 0;

  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  fgw_port dut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_bus(bus),
    .i_pin_in(pins), .i_func_sel(func), .i_analog_sel(ana),
    .i_ext_irq(ext_irq), .o_rdata(rdata), .o_pin_out(out), .o_pin_oe(oe),
    .o_shared_external_irq_line(irq), .o_wake(wake));
  fgw_pad_model pads (.i_out(out), .i_oe(oe), .i_ext(ext), .o_pin(pins));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wr(input fgw_addr_t a, input logic [31:0] d,
                    input logic [3:0] be);
    @(posedge i_sys_clk);
    bus <= '{addr: a, wdata: d, be: be, wr: 1'b1, rd: 1'b0};
    @(posedge i_sys_clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input fgw_addr_t a, input logic [31:0] want);
    @(posedge i_sys_clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, be: 4'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_sys_clk);
    bus.rd <= 1'b0;
    #1;
    check(rdata, want);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic t_reset();
    rd_chk(`FGW_OFF_DIR, 32'h0000_0000);
    for (int p = 0; p < 5; p++) check(oe[p], 32'h0000_0000);
  endtask

  task automatic t_outputs();
    wr(p1_base + `FGW_OFF_DIR, 32'hFFFF_FFFF, 4'hF);
    @(posedge i_sys_clk);
    func[1] <= 32'h0000_0001;
    idle(2);
    check(oe[1], 32'hFFFF_FFFE);
    wr(p1_base + `FGW_OFF_SET, 32'hFFFF_FFFF, 4'b0001);
    check(out[1], 32'h0000_00FF);
    wr(p1_base + `FGW_OFF_CLR, 32'h0000_000F, 4'hF);
    check(out[1], 32'h0000_00F0);
    wr(p1_base + `FGW_OFF_SET, 32'h0000_FF00, 4'b1100);
    check(out[1], 32'h0000_00F0);
    wr(p1_base + `FGW_OFF_MASK, 32'h0000_FFFF, 4'hF);
    wr(p1_base + `FGW_OFF_PIN, 32'hAAAA_AAAA, 4'hF);
    check(out[1], 32'hAAAA_00F0);
    idle(4);
    rd_chk(p1_base + `FGW_OFF_PIN, 32'hAAAA_0000);
    rd_chk(p1_base + `FGW_OFF_SET, 32'hAAAA_00F0);
    wr(p1_base + `FGW_OFF_DIR, 32'h0000_FFFF, 4'hF);
    idle(1);
    check(oe[1], 32'h0000_FFFE);
  endtask

  // legacy pin read ignores the port 1 mask left by the previous task
  task automatic t_legacy();
    wr(leg1 + `FGW_LEG_PIN, 32'h1234_5678, 4'hF);
    check(out[1], 32'h1234_5678);
    wr(leg1 + `FGW_LEG_SET, 32'h0000_0F00, 4'hF);
    check(out[1], 32'h1234_5F78);
    wr(leg1 + `FGW_LEG_CLR, 32'h0000_0078, 4'hF);
    check(out[1], 32'h1234_5F00);
    rd_chk(leg1 + `FGW_LEG_SET, 32'h1234_5F00);
    rd_chk(leg1 + `FGW_LEG_DIR, 32'h0000_FFFF);
    rd_chk(leg1 + `FGW_LEG_PIN, 32'h0000_5F00);
    rd_chk(12'hFFC, 32'h0000_0000);
  endtask

  // bit 3 has both edges enabled, bit 7 is analog and must stay silent
  task automatic t_edges();
    @(posedge i_sys_clk);
    ana[0] <= 32'h0000_0080;
    wr(ie0 + `FGW_INT_REN, 32'h0000_0008, 4'hF);
    wr(ie0 + `FGW_INT_FEN, 32'h0000_0008, 4'hF);
    rd_chk(ie0 + `FGW_INT_REN, 32'h0000_0008);
    @(posedge i_sys_clk);
    ext[0] <= 32'h0000_0088;
    idle(6);
    rd_chk(ie0 + `FGW_INT_RST, 32'h0000_0008);
    check(32'(irq), 32'h0000_0001);
    check(32'(wake), 32'h0000_0001);
    idle(20);
    rd_chk(ie0 + `FGW_INT_RST, 32'h0000_0008);
    wr(ie0 + `FGW_INT_CLR, 32'h0000_0008, 4'hF);
    idle(2);
    check(32'(irq), 32'h0000_0000);
    rd_chk(ie0 + `FGW_INT_RST, 32'h0000_0000);
    @(posedge i_sys_clk);
    ext[0] <= 32'h0000_0000;
    idle(6);
    rd_chk(ie0 + `FGW_INT_FST, 32'h0000_0008);
    check(32'(wake), 32'h0000_0001);
    wr(ie0 + `FGW_INT_CLR, 32'hFFFF_FFFF, 4'hF);
    @(posedge i_sys_clk);
    ext[2] <= 32'h0000_0001;
    idle(6);
    rd_chk(ie1 + `FGW_INT_RST, 32'h0000_0001);
    check(32'(irq), 32'h0000_0000);
    @(posedge i_sys_clk);
    ext_irq <= 1'b1;
    idle(2);
    check(32'(irq), 32'h0000_0001);
  endtask

  // port 0 bits 0..3 driven, so the latch itself makes the edges
  task automatic t_port0();
    wr(ie0 + `FGW_INT_REN, 32'h0000_0001, 4'hF);
    wr(`FGW_OFF_DIR, 32'hFFFF_FF0F, 4'h1);
    rd_chk(`FGW_OFF_DIR, 32'h0000_000F);
    wr(`FGW_OFF_SET, 32'h0000_0101, 4'hF);
    check(out[0], 32'h0000_0101);
    idle(4);
    check(32'(wake), 32'h0000_0001);
    rd_chk(ie0 + `FGW_INT_RST, 32'h0000_0001);
    wr(`FGW_OFF_CLR, 32'h0000_0001, 4'hF);
    check(out[0], 32'h0000_0100);
    @(posedge i_sys_clk);
    ext[0] <= 32'h0000_0300;
    wr(`FGW_OFF_MASK, 32'h0000_0200, 4'hF);
    idle(2);
    rd_chk(`FGW_OFF_PIN, 32'h0000_0100);
    rd_chk(ie0 + `FGW_INT_FST, 32'h0000_0001);
  endtask

  // a reset in mid-run must drop every driver and clear the latches
  task automatic t_rereset();
    @(posedge i_sys_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    #1;
    for (int p = 0; p < 5; p++) begin
      check(oe[p], 32'h0000_0000);
      check(out[p], 32'h0000_0000);
    end
    rd_chk(p1_base + `FGW_OFF_DIR, 32'h0000_0000);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    #1;
    t_reset();
    t_outputs();
    t_legacy();
    t_edges();
    t_port0();
    t_rereset();
    close_out();
  end

  // whole run is about 150 cycles; this span leaves ample margin
  initial begin
    #40000;
    fails++;
    close_out();
  end
endmodule

`default_nettype wire
